//--- switch_latch_pkg.sv
package switch_latch_pkg;

  localparam int CHANNEL_COUNT = 8;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [7:0] CHANNELS_RESET = 8'h00;
  localparam int LAST_STAGE = 7;
  localparam int RESET_SYNC_STAGES = 2;

  typedef struct packed {
    logic data;
    logic clk;
    logic hold_strobe_n;
  } serial_in_s;

  // Idle levels, so no false shift edge follows reset
  localparam serial_in_s PINS_RESET = '{data: 1'h0, clk: 1'h0, hold_strobe_n: 1'h1};

endpackage : switch_latch_pkg

//--- hold_latch.sv
`timescale 1ns/1ps
module hold_latch
  import switch_latch_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_shift,
  input wire logic i_hold_strobe_n,
  output logic [WIDTH-1:0] o_latched
);

  // Transparent while strobe low; keeps last value while high
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_latched <= WIDTH'(CHANNELS_RESET);
    end else if (!i_hold_strobe_n) begin
      o_latched <= i_shift;
    end
  end

endmodule : hold_latch

//--- serial_switch_control_latch.sv
// Operation
// - Serial input sampled, register shifted on each shift clock rising edge.
// - Eight-bit shift register feeds eight-bit latch driving switch channels.
// - Hold strobe low: latch transparent, shift contents reach channels.
// - Hold strobe rising: latch captures and keeps states while high.
// - Hold strobe high: shifting changes only shift register, never channels.
// - Each channel follows only its own latched bit.
// - Serial output high when channel 7 control bit would turn it on.
`timescale 1ns/1ps
module serial_switch_control_latch
  import switch_latch_pkg::*;
#(
  parameter int WIDTH = CHANNEL_COUNT
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_serial_data,
  input wire logic i_shift_clk,
  input wire logic i_hold_strobe_n,
  output logic [WIDTH-1:0] o_channel_on,
  output logic o_serial_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // One-cycle edge on a sampled level; both pins use it
  function automatic logic rising(
    input logic level_now,
    input logic level_before
  );
    return level_now && !level_before;
  endfunction : rising

  // Newest bit enters position zero, oldest leaves the top
  function automatic logic [WIDTH-1:0] shift_in(
    input logic [WIDTH-1:0] word,
    input logic bit_in
  );
    return {word[WIDTH-2:0], bit_in};
  endfunction : shift_in

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [RESET_SYNC_STAGES-1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync <= '0;
    end else begin
      rst_sync <= {rst_sync[RESET_SYNC_STAGES-2:0], 1'h1};
    end
  end

  // Only the last stage is read; the first may still be settling
  assign rst_n = rst_sync[RESET_SYNC_STAGES-1];

  ////////////////////////////////////////////////////////////////////////////
  // Input capture; pins treated as synchronous to the system clock
  serial_in_s pins;
  serial_in_s pins_q;

  assign pins = '{data: i_serial_data, clk: i_shift_clk, hold_strobe_n: i_hold_strobe_n};

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins_q <= PINS_RESET;
    end else begin
      pins_q <= pins;
    end
  end

  // Edge found from registered copy, data taken with the edge
  logic shift_edge;
  logic strobe_rise;
  assign shift_edge = rising(pins.clk, pins_q.clk);
  // Strobe rise is watched by checks only; the latch reads the level
  assign strobe_rise = rising(pins.hold_strobe_n, pins_q.hold_strobe_n);

  ////////////////////////////////////////////////////////////////////////////
  // Shift register, bit 0 enters first position
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] next_shift;

  assign next_shift = shift_in(shift_reg, pins.data);

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= WIDTH'(SHIFT_RESET);
    end else if (shift_edge) begin
      shift_reg <= next_shift;
    end
  end

  // Shifts taken while held; feeds checks only, saturates at one word
  localparam int COUNT_W = $clog2(WIDTH + 1);
  logic [COUNT_W-1:0] held_shifts;

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      held_shifts <= '0;
    end else if (!pins.hold_strobe_n) begin
      held_shifts <= '0;
    end else if (shift_edge && (held_shifts != COUNT_W'(WIDTH))) begin
      held_shifts <= held_shifts + COUNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latch stage; clocked copy, so channels lag the register by two cycles
  logic [WIDTH-1:0] latched;

  // Strobe level goes straight in, so a hold takes effect on the same edge
  hold_latch #(
    .WIDTH(WIDTH)
  ) u_latch (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_shift(shift_reg),
    .i_hold_strobe_n(pins.hold_strobe_n),
    .o_latched(latched)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, one flop each; bit n drives channel n, one means on
  // Registered so a channel never sees the latch mid-update
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_channel_on <= WIDTH'(CHANNELS_RESET);
    end else begin
      o_channel_on <= latched;
    end
  end

  // Last stage for cascading, tracks channel 7 control
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_serial_out <= 1'h0;
    end else begin
      o_serial_out <= latched[LAST_STAGE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Shift edge at E, latch at E+1, channels at E+2
  chk_shift_advance: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    shift_edge |=> shift_reg == shift_in($past(shift_reg), $past(i_serial_data)))
    else $error("shift register did not advance on shift edge");

  chk_shift_idle: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    !shift_edge |=> $stable(shift_reg))
    else $error("shift register moved without shift edge");

  chk_transparent: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    !i_hold_strobe_n |=> ##1 o_channel_on == $past(shift_reg, 2))
    else $error("channels not following shift register while strobe low");

  chk_hold_capture: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $rose(i_hold_strobe_n) |=> latched == $past(latched))
    else $error("latch not held on strobe rise");

  chk_hold_stable: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (i_hold_strobe_n && shift_edge) |=> $stable(latched))
    else $error("shifting changed switch state while held");

  chk_channel_map: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    1'h1 |=> o_channel_on == $past(latched))
    else $error("channel output not equal to its latched bit");

  chk_serial_out: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    o_serial_out == o_channel_on[LAST_STAGE])
    else $error("serial output differs from channel 7 state");

  chk_bit_order: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    shift_edge |=> shift_reg[0] == $past(i_serial_data))
    else $error("new bit did not enter position zero");

  chk_capture_value: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    strobe_rise |=> latched == $past(shift_reg, 2))
    else $error("latch did not keep the word present at strobe rise");

  chk_latch_follow: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    !pins.hold_strobe_n |=> latched == $past(shift_reg))
    else $error("latch not transparent while strobe low");

  chk_latch_held: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    i_hold_strobe_n |=> $stable(latched))
    else $error("latch changed while strobe high");

  chk_channels_held: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    i_hold_strobe_n |=> ##1 $stable(o_channel_on))
    else $error("channel outputs changed while strobe high");

  chk_serial_held: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    i_hold_strobe_n |=> ##1 $stable(o_serial_out))
    else $error("serial output changed while strobe high");

  chk_level_no_shift: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    (pins.clk && pins_q.clk) |=> $stable(shift_reg))
    else $error("shift register moved while shift clock stayed high");

  chk_serial_track: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    1'h1 |=> o_serial_out == $past(latched[LAST_STAGE]))
    else $error("serial output not following channel 7 control");

  chk_top_stage: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    shift_edge |=> shift_reg[WIDTH-1] == $past(shift_reg[WIDTH-2]))
    else $error("top stage did not take the bit below it");

  // Reset clears every stage so no channel turns on before the first load
  chk_reset_off: assert property (@(posedge i_clk_sys)
    !rst_n |-> (shift_reg == WIDTH'(SHIFT_RESET))
      && (o_channel_on == WIDTH'(CHANNELS_RESET)) && !o_serial_out)
    else $error("outputs not cleared during reset");

  cov_shift: cover property (@(posedge i_clk_sys) disable iff (!rst_n) shift_edge);
  cov_hold_shift: cover property (@(posedge i_clk_sys) disable iff (!rst_n)
    i_hold_strobe_n && shift_edge);
  cov_ch7_on: cover property (@(posedge i_clk_sys) disable iff (!rst_n) $rose(o_serial_out));
  cov_strobe_rise: cover property (@(posedge i_clk_sys) disable iff (!rst_n) strobe_rise);
  cov_full_held_word: cover property (@(posedge i_clk_sys) disable iff (!rst_n)
    held_shifts == COUNT_W'(WIDTH));

endmodule : serial_switch_control_latch

//--- host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic i_clk_sys,
  input wire logic i_go,
  input wire logic [7:0] i_word,
  output logic o_data,
  output logic o_sclk,
  output logic o_busy
);
  logic [7:0] word = 8'h00;
  logic [3:0] cnt = 4'h0;
  initial {o_data, o_sclk, o_busy} = 3'h0;
  // Data toggles when idle so nothing relies on a stale bit
  always @(posedge i_clk_sys) begin
    if (!o_busy) begin
      o_data <= ~o_data;
      if (i_go) begin
        {word, cnt, o_busy} <= {i_word, 4'h0, 1'h1};
      end
    end else if (o_sclk) begin
      o_sclk <= 1'h0;
    end else if (cnt == 4'h8) begin
      o_busy <= 1'h0;
    end else begin
      // First bit sent lands in channel 7
      o_data <= word[7];
      o_sclk <= 1'h1;
      word <= word << 1;
      cnt <= cnt + 4'h1;
    end
  end
endmodule : host_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 1'h0, rst_n = 1'h0, go = 1'h0, hold_n = 1'h0;
  logic [7:0] word = 8'h00, ch;
  logic data, sclk, busy, sout;
  int error_cnt = 0, checked = 0, n;
  initial forever #4 clk = ~clk;
  host_model u_host_model (.i_clk_sys(clk), .i_go(go), .i_word(word), .o_data(data),
    .o_sclk(sclk), .o_busy(busy));
  serial_switch_control_latch u_serial_switch_control_latch (.i_clk_sys(clk),
    .i_rst_n(rst_n), .i_serial_data(data), .i_shift_clk(sclk),
    .i_hold_strobe_n(hold_n), .o_channel_on(ch), .o_serial_out(sout));
  ////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("Counts: %0d checks, %0d mismatches", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task chk(input logic [7:0] e_ch, input logic e_so);
    checked++;
    if (ch !== e_ch || sout !== e_so) begin
      error_cnt++;
      $display("Error %0t: channels %h out %b, want %h %b", $time, ch, sout, e_ch, e_so);
    end
  endtask : chk
  // Frame done is seen by busy falling; output lag is two edges
  task send(input logic [7:0] w);
    @(posedge clk);
    word <= w;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (busy === 1'h0) break;
    end
    if (n == 40) begin
      error_cnt++;
      $display("Error %0t: frame timeout", $time);
      final_report();
    end
    repeat (4) @(posedge clk);
    #1;
  endtask : send
  ////////////////////////////////////////////////////////////////////////
  task test_transparent;
    send(8'hA5);
    chk(8'hA5, 1'h1);
    send(8'h01);
    chk(8'h01, 1'h0);
    $display("test_transparent done");
  endtask : test_transparent
  task test_hold;
    @(posedge clk) hold_n <= 1'h1;
    send(8'h5A);
    chk(8'h01, 1'h0);
    @(posedge clk) hold_n <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
    chk(8'h5A, 1'h0);
    send(8'h80);
    chk(8'h80, 1'h1);
    $display("test_hold done");
  endtask : test_hold
  // Mid-run reset clears loaded channels, then a fresh word loads again
  task test_reset;
    @(posedge clk) rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk(8'h00, 1'h0);
    @(posedge clk) rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
    chk(8'h00, 1'h0);
    send(8'h3C);
    chk(8'h3C, 1'h0);
    $display("test_reset done");
  endtask : test_reset
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
    chk(8'h00, 1'h0);
    test_transparent();
    test_hold();
    test_reset();
    final_report();
  end
endmodule : testbench
